// ==== cke_params.svh ====
/*
  timing counts and field positions for the clock-enable state block.
  assumes a single 125 MHz clock; counts are in clock cycles.
*/
`ifndef CKE_PARAMS_SVH
`define CKE_PARAMS_SVH
`define MR1_DLL_BIT 0
`define MR1_SEL 3'h1
`define DLLOFF_CL 5'h0a
`define DLLOFF_CWL 5'h09
`define CKE_MIN_CYC 4'h4
`define MRD_CYC 4'h8
`define MOD_CYC 5'h18
`define XS_CYC 8'h30
`define XSDLL_CYC 10'h200
`define BURST_CYC 4'h4
`endif

// ==== cke_pkg.sv ====
/*
  types shared by both ends: commands and device states.
  assumes cke_params.svh carries the numbers.
*/
package cke_pkg;
  typedef enum logic [3:0] {
    cmd_des, cmd_nop, cmd_act, cmd_rd, cmd_wr, cmd_pre, cmd_prea, cmd_ref, cmd_mrs, cmd_zq, cmd_bad
  } cmd_type;
  typedef enum logic [2:0] {
    st_idle, st_active, st_busy, st_refreshing, st_pd_pre, st_pd_act, st_self_refresh
  } dev_state_type;
endpackage

// ==== dram_link_if.sv ====
/*
  command and clock-enable link between controller and memory device end.
  assumes both ends share mclk; the controller drives every signal but dqs.
*/
`timescale 1ns/100ps
`default_nettype none
interface dram_link_if;
  logic cke;
  logic cs_n;
  logic act_n;
  logic ras_n;
  logic cas_n;
  logic we_n;
  logic [2:0] ba;
  logic [13:0] addr;
  logic odt;
  logic dqs_start;
  modport device (input cke, cs_n, act_n, ras_n, cas_n, we_n, ba, addr, odt, output dqs_start);
  modport ctrl (output cke, cs_n, act_n, ras_n, cas_n, we_n, ba, addr, odt, input dqs_start);
endinterface
`default_nettype wire

// ==== cmd_decode.sv ====
/*
  decodes registered command pins into a command code.
  assumes pins are already sampled on mclk.
*/
`timescale 1ns/100ps
`default_nettype none
module cmd_decode
  import cke_pkg::*;
(
  input wire logic cs_n,
  input wire logic act_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic a10,
  output cke_pkg::cmd_type cmd
);
  always_comb begin
    if (cs_n) begin
      cmd = cmd_des;
    end else if (!act_n) begin
      cmd = cmd_act;
    end else begin
      case ({ras_n, cas_n, we_n})
        3'h7: cmd = cmd_nop;
        3'h5: cmd = cmd_rd;
        3'h4: cmd = cmd_wr;
        3'h2: cmd = a10 ? cmd_prea : cmd_pre;
        3'h1: cmd = cmd_ref;
        3'h0: cmd = cmd_mrs;
        3'h6: cmd = cmd_zq;
        default: cmd = cmd_bad;
      endcase
    end
  end
endmodule
`default_nettype wire

// ==== dram_cke_device.sv ====
/*
  device end: clock-enable state machine, power-down and self refresh,
  dll-off mode and read strobe start timing.
  assumes the controller keeps its own obligations on the link.
*/
`timescale 1ns/100ps
`default_nettype none
`include "cke_params.svh"
module dram_cke_device
  import cke_pkg::*;
(
  input wire logic mclk,
  input wire logic srst,
  dram_link_if.device link,
  input wire logic [4:0] al,
  output logic dll_on,
  output logic odt_active,
  output logic illegal,
  output logic refresh_busy,
  output cke_pkg::dev_state_type state
);
  import cke_pkg::*;
  cmd_type cmd;
  dev_state_type state_ff, nxt_state;
  logic cke_prev_ff;
  logic [7:0] bank_open_ff;
  logic [3:0] busy_cnt_ff;
  logic [4:0] cl_ff;
  logic dll_on_ff;
  logic [5:0] rd_cnt_ff;
  logic rd_pend_ff;
  logic dqs_ff;
  logic ill_ff;
  logic odt_ff;
  logic rfsh_ff;
  logic ena;
  logic busy_after;
  logic [5:0] rd_lat;

  cmd_decode u_dec (
    .cs_n(link.cs_n),
    .act_n(link.act_n),
    .ras_n(link.ras_n),
    .cas_n(link.cas_n),
    .we_n(link.we_n),
    .a10(link.addr[10]),
    .cmd(cmd)
  );

  // commands count only when cke is high now and was high before, except a refresh on a falling cke from idle
  assign ena = cke_prev_ff & link.cke;
  assign busy_after = (state_ff == st_busy) && (busy_cnt_ff > 4'h1);

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      st_pd_pre, st_pd_act: begin
        if (!cke_prev_ff && link.cke) begin
          nxt_state = (bank_open_ff == 8'h00) ? st_idle : st_active;
        end
      end
      st_self_refresh: begin
        if (!cke_prev_ff && link.cke) begin
          nxt_state = st_idle;
        end
      end
      st_refreshing: begin
        if (cke_prev_ff && !link.cke) begin
          nxt_state = st_pd_pre;
        end else if (busy_cnt_ff == 4'h1) begin
          nxt_state = st_idle;
        end
      end
      st_busy: begin
        if (cke_prev_ff && !link.cke) begin
          nxt_state = (bank_open_ff == 8'h00) ? st_pd_pre : st_pd_act;
        end else if (busy_cnt_ff == 4'h1) begin
          nxt_state = (bank_open_ff == 8'h00) ? st_idle : st_active;
        end
      end
      st_active: begin
        if (cke_prev_ff && !link.cke) begin
          nxt_state = st_pd_act;
        end else if (ena && (cmd == cmd_rd || cmd == cmd_wr || cmd == cmd_pre || cmd == cmd_prea)) begin
          nxt_state = st_busy;
        end
      end
      st_idle: begin
        if (cke_prev_ff && !link.cke) begin
          // refresh with a falling cke from idle enters self refresh
          nxt_state = (cmd == cmd_ref) ? st_self_refresh : st_pd_pre;
        end else if (ena && cmd == cmd_ref) begin
          nxt_state = st_refreshing;
        end else if (ena && cmd == cmd_act) begin
          nxt_state = st_active;
        end
      end
      default: nxt_state = st_idle;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      state_ff <= st_idle;
      cke_prev_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cke_prev_ff <= link.cke;
    end
  end

  // bank bookkeeping; activate opens, precharge closes
  always_ff @(posedge mclk) begin
    if (srst) begin
      bank_open_ff <= 8'h00;
    end else if (ena && (state_ff == st_idle || state_ff == st_active || state_ff == st_busy)) begin
      if (cmd == cmd_act) begin
        bank_open_ff[link.ba] <= 1'b1;
      end else if (cmd == cmd_prea) begin
        bank_open_ff <= 8'h00;
      end else if (cmd == cmd_pre) begin
        bank_open_ff[link.ba] <= 1'b0;
      end
    end
  end

  // busy countdown covers bursts and internal refresh; it clears to zero in power-down
  always_ff @(posedge mclk) begin
    if (srst) begin
      busy_cnt_ff <= 4'h0;
    end else if (nxt_state == st_pd_pre || nxt_state == st_pd_act) begin
      busy_cnt_ff <= 4'h0;
    end else if (ena && state_ff == st_idle && cmd == cmd_ref) begin
      busy_cnt_ff <= `BURST_CYC;
    end else if (ena && state_ff == st_active && cmd != cmd_des && cmd != cmd_act) begin
      busy_cnt_ff <= `BURST_CYC;
    end else if (busy_cnt_ff != 4'h0) begin
      busy_cnt_ff <= busy_cnt_ff - 4'h1;
    end
  end

  // mode register 1 bit a0 steers dll; cl resets to 10 and mode register 0 sets it to 10 plus its field
  always_ff @(posedge mclk) begin
    if (srst) begin
      dll_on_ff <= 1'b1;
      cl_ff <= `DLLOFF_CL;
    end else if (ena && state_ff == st_idle && cmd == cmd_mrs) begin
      if (link.ba == `MR1_SEL) begin
        dll_on_ff <= link.addr[`MR1_DLL_BIT];
      end else if (link.ba == 3'h0) begin
        cl_ff <= {1'b0, link.addr[6:4], link.addr[2]} + `DLLOFF_CL;
      end
    end
  end

  // dll off starts the strobe one cycle earlier
  assign rd_lat = dll_on_ff ? ({1'b0, al} + {1'b0, cl_ff}) : ({1'b0, al} + {1'b0, cl_ff} - 6'h01);

  always_ff @(posedge mclk) begin
    if (srst) begin
      rd_pend_ff <= 1'b0;
      rd_cnt_ff <= 6'h00;
      dqs_ff <= 1'b0;
    end else begin
      dqs_ff <= 1'b0;
      if (ena && state_ff == st_active && cmd == cmd_rd) begin
        rd_pend_ff <= 1'b1;
        rd_cnt_ff <= rd_lat - 6'h01;
      end else if (rd_pend_ff) begin
        if (rd_cnt_ff <= 6'h01) begin
          rd_pend_ff <= 1'b0;
          dqs_ff <= 1'b1;
        end else begin
          rd_cnt_ff <= rd_cnt_ff - 6'h01;
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      odt_ff <= 1'b0;
      rfsh_ff <= 1'b0;
    end else begin
      odt_ff <= link.odt && nxt_state != st_self_refresh;
      rfsh_ff <= nxt_state == st_self_refresh || nxt_state == st_refreshing;
    end
  end

  // flags combinations outside the legal set
  always_ff @(posedge mclk) begin
    if (srst) begin
      ill_ff <= 1'b0;
    end else begin
      ill_ff <= 1'b0;
      if (cke_prev_ff != link.cke && cmd != cmd_des && !(state_ff == st_idle && cmd == cmd_ref && !link.cke)) begin
        ill_ff <= 1'b1;
      end else if (cke_prev_ff && !link.cke && state_ff == st_active && busy_after) begin
        ill_ff <= 1'b1;
      end else if (ena && cmd == cmd_bad) begin
        ill_ff <= 1'b1;
      end
    end
  end

  assign link.dqs_start = dqs_ff;
  assign dll_on = dll_on_ff;
  assign odt_active = odt_ff;
  assign illegal = ill_ff;
  assign refresh_busy = rfsh_ff;
  assign state = state_ff;
endmodule
`default_nettype wire

// ==== dram_cke_ctrl.sv ====
/*
  controller end: drives cke and commands, keeps cke hold, mode delays and
  self refresh exit delays. assumes user requests are one-cycle pulses.
*/
`timescale 1ns/100ps
`default_nettype none
`include "cke_params.svh"
module dram_cke_ctrl
  import cke_pkg::*;
(
  input wire logic mclk,
  input wire logic srst,
  dram_link_if.ctrl link,
  input wire logic req_valid,
  input wire cke_pkg::cmd_type req_cmd,
  input wire logic [2:0] req_ba,
  input wire logic [13:0] req_addr,
  input wire logic req_pd,
  input wire logic req_sr,
  input wire logic req_wake,
  input wire logic req_odt,
  input wire logic data_busy,
  output logic req_ready,
  output logic dqs_seen
);
  import cke_pkg::*;
  logic cke_ff, cs_n_ff, act_n_ff, ras_n_ff, cas_n_ff, we_n_ff, odt_ff, rdy_ff, in_sr_ff, dqs_ff;
  logic [2:0] ba_ff;
  logic [13:0] addr_ff;
  logic [3:0] hold_ff;
  logic [4:0] mod_ff;
  logic [9:0] xs_ff;
  logic can_cmd;
  logic mode_ok;
  logic go_rd;
  logic dll_win_ff;
  logic mr1_ok;
  logic win_close;

  assign mode_ok = mod_ff == 5'h00;
  assign can_cmd = cke_ff && hold_ff == 4'h0 && xs_ff < `XSDLL_CYC - {2'h0, `XS_CYC};
  assign go_rd = req_cmd != cmd_rd || xs_ff == 10'h000;
  assign mr1_ok = req_cmd != cmd_mrs || req_ba != `MR1_SEL || dll_win_ff;
  // a refused request still closes the window; stricter than needed, never looser
  assign win_close = req_pd || req_sr || (req_valid && req_cmd != cmd_mrs && req_cmd != cmd_zq);

  always_ff @(posedge mclk) begin
    if (srst) begin
      cke_ff <= 1'b0;
      {cs_n_ff, act_n_ff, ras_n_ff, cas_n_ff, we_n_ff} <= 5'h1f;
      ba_ff <= 3'h0;
      addr_ff <= 14'h0000;
      hold_ff <= `CKE_MIN_CYC;
      mod_ff <= 5'h00;
      xs_ff <= 10'h000;
      in_sr_ff <= 1'b0;
      rdy_ff <= 1'b0;
      odt_ff <= 1'b0;
    end else begin
      {cs_n_ff, act_n_ff, ras_n_ff, cas_n_ff, we_n_ff} <= 5'h1f;
      rdy_ff <= 1'b0;
      odt_ff <= req_odt && xs_ff == 10'h000 && !in_sr_ff;
      if (hold_ff != 4'h0) begin
        hold_ff <= hold_ff - 4'h1;
      end
      if (mod_ff != 5'h00) begin
        mod_ff <= mod_ff - 5'h01;
      end
      if (xs_ff != 10'h000) begin
        xs_ff <= xs_ff - 10'h001;
      end
      if (!cke_ff) begin
        if (req_wake && hold_ff == 4'h0) begin
          cke_ff <= 1'b1;
          hold_ff <= `CKE_MIN_CYC - 4'h1;
          if (in_sr_ff) begin
            xs_ff <= `XSDLL_CYC;
          end
          in_sr_ff <= 1'b0;
        end
      end else if (can_cmd && mode_ok && req_sr && !data_busy) begin
        cke_ff <= 1'b0;
        hold_ff <= `CKE_MIN_CYC - 4'h1;
        {cs_n_ff, act_n_ff, ras_n_ff, cas_n_ff, we_n_ff} <= 5'h09;
        in_sr_ff <= 1'b1;
      end else if (can_cmd && mode_ok && req_pd) begin
        cke_ff <= 1'b0;
        hold_ff <= `CKE_MIN_CYC - 4'h1;
      end else if (can_cmd && req_valid && go_rd && mr1_ok && req_cmd != cmd_nop && req_cmd != cmd_bad) begin
        // nop is never sent: it is reserved for power-save exit and gear-down
        rdy_ff <= 1'b1;
        ba_ff <= req_ba;
        addr_ff <= req_addr;
        case (req_cmd)
          cmd_act: {cs_n_ff, act_n_ff} <= 2'h0;
          cmd_rd: {cs_n_ff, act_n_ff, ras_n_ff, cas_n_ff, we_n_ff} <= 5'h0d;
          cmd_wr: {cs_n_ff, act_n_ff, ras_n_ff, cas_n_ff, we_n_ff} <= 5'h0c;
          cmd_pre, cmd_prea: begin
            {cs_n_ff, act_n_ff, ras_n_ff, cas_n_ff, we_n_ff} <= 5'h0a;
            addr_ff[10] <= req_cmd == cmd_prea;
          end
          cmd_ref: {cs_n_ff, act_n_ff, ras_n_ff, cas_n_ff, we_n_ff} <= 5'h09;
          cmd_mrs: begin
            {cs_n_ff, act_n_ff, ras_n_ff, cas_n_ff, we_n_ff} <= 5'h08;
            mod_ff <= `MOD_CYC;
          end
          cmd_zq: {cs_n_ff, act_n_ff, ras_n_ff, cas_n_ff, we_n_ff} <= 5'h0e;
          default: rdy_ff <= 1'b0;
        endcase
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      dqs_ff <= 1'b0;
    end else begin
      dqs_ff <= link.dqs_start;
    end
  end

  // dll bit may move after reset or on self refresh exit, until the first request other than mrs or zq, refused or not
  always_ff @(posedge mclk) begin
    if (srst) begin
      dll_win_ff <= 1'b1;
    end else if (!cke_ff && in_sr_ff && req_wake && hold_ff == 4'h0) begin
      dll_win_ff <= 1'b1;
    end else if (cke_ff && can_cmd && win_close) begin
      dll_win_ff <= 1'b0;
    end
  end

  assign link.cke = cke_ff;
  assign link.cs_n = cs_n_ff;
  assign link.act_n = act_n_ff;
  assign link.ras_n = ras_n_ff;
  assign link.cas_n = cas_n_ff;
  assign link.we_n = we_n_ff;
  assign link.ba = ba_ff;
  assign link.addr = addr_ff;
  assign link.odt = odt_ff;
  assign req_ready = rdy_ff;
  assign dqs_seen = dqs_ff;
endmodule
`default_nettype wire

// ==== dram_cke_assertions.sv ====
/* checker for the link that joins controller end and device end.
   assumes tb_top wires the link signals, mclk, srst and al in by name. */
`timescale 1ns/100ps
`default_nettype none
`include "cke_params.svh"
module dram_cke_assertions (
  input wire logic mclk,
  input wire logic srst,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic act_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [2:0] ba,
  input wire logic [13:0] addr,
  input wire logic dqs_start,
  input wire logic [4:0] al
);
  logic cke_ff, sr_ff, dll_ff, dll_win_ff;
  logic [7:0] cke_age_ff, mrs_age_ff;
  logic [9:0] srx_age_ff;
  logic [5:0] rd_due_ff;
  wire logic is_mrs = cke && !cs_n && act_n && !ras_n && !cas_n && !we_n;
  wire logic is_ref = !cs_n && act_n && !ras_n && !cas_n && we_n;
  wire logic is_rd = cke && !cs_n && act_n && ras_n && !cas_n && we_n;
  wire logic is_zq = !cs_n && act_n && ras_n && cas_n && !we_n;

  // ages saturate so a long quiet stretch never wraps into a false window
  always_ff @(posedge mclk) begin
    cke_ff <= srst ? 1'b0 : cke;
    if (srst || cke != cke_ff) cke_age_ff <= 8'h00;
    else if (cke_age_ff != 8'hff) cke_age_ff <= cke_age_ff + 8'h01;
  end
  always_ff @(posedge mclk) begin
    if (srst) mrs_age_ff <= 8'hff;
    else if (is_mrs) mrs_age_ff <= 8'h00;
    else if (mrs_age_ff != 8'hff) mrs_age_ff <= mrs_age_ff + 8'h01;
  end
  always_ff @(posedge mclk) begin
    if (srst || (!cke_ff && cke)) sr_ff <= 1'b0;
    else if (cke_ff && !cke && is_ref) sr_ff <= 1'b1;
    if (srst) srx_age_ff <= 10'h3ff;
    else if (!cke_ff && cke && sr_ff) srx_age_ff <= 10'h000;
    else if (srx_age_ff != 10'h3ff) srx_age_ff <= srx_age_ff + 10'h001;
  end
  // dll state rebuilt from mode register 1 writes seen on the link; read latency is al plus cl 10, one less with dll off
  always_ff @(posedge mclk) begin
    if (srst) dll_ff <= 1'b1;
    else if (is_mrs && ba == `MR1_SEL) dll_ff <= addr[`MR1_DLL_BIT];
    if (srst) rd_due_ff <= 6'h00;
    else if (is_rd) rd_due_ff <= 6'(al) + (dll_ff ? 6'(`DLLOFF_CL) : 6'(`DLLOFF_CL - 1));
    else if (rd_due_ff != 6'h00) rd_due_ff <= rd_due_ff - 6'h01;
  end

  // window for dll bit changes: open after reset or self refresh exit
  always_ff @(posedge mclk) begin
    if (srst || (!cke_ff && cke && sr_ff)) dll_win_ff <= 1'b1;
    else if ((cke && !cs_n && !is_mrs && !is_zq) || (cke_ff && !cke)) dll_win_ff <= 1'b0;
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  property p_cke_edge_des; (cke != cke_ff) |-> cs_n || (cke_ff && is_ref); endproperty
  a_cke_edge_des: assert property (p_cke_edge_des) else $error("command on a cke edge");
  property p_sr_entry; $fell(cke) && !cs_n |-> is_ref; endproperty
  a_sr_entry: assert property (p_sr_entry) else $error("cke fall with non-refresh command");
  property p_cke_hold; !$stable(cke) |-> cke_age_ff >= 8'(`CKE_MIN_CYC - 1); endproperty
  a_cke_hold: assert property (p_cke_hold) else $error("cke changed too soon");
  property p_mod_gap; cke_ff && !cke |-> mrs_age_ff >= 8'(`MOD_CYC - 1); endproperty
  a_mod_gap: assert property (p_mod_gap) else $error("cke low too soon after mode write");
  property p_xs_des; srx_age_ff < 10'(`XS_CYC - 1) |-> cs_n; endproperty
  a_xs_des: assert property (p_xs_des) else $error("command inside self refresh exit delay");
  property p_xsdll_rd; is_rd |-> srx_age_ff >= 10'(`XSDLL_CYC - 1); endproperty
  a_xsdll_rd: assert property (p_xsdll_rd) else $error("read before dll exit delay");
  property p_no_nop; !cs_n |-> !(act_n && ras_n && cas_n && we_n); endproperty
  a_no_nop: assert property (p_no_nop) else $error("nop encoding driven");
  property p_dqs_due; rd_due_ff == 6'h01 |-> dqs_start; endproperty
  a_dqs_due: assert property (p_dqs_due) else $error("read strobe start missing");
  property p_dqs_only; dqs_start |-> rd_due_ff == 6'h01; endproperty
  a_dqs_only: assert property (p_dqs_only) else $error("read strobe start at wrong edge");
  property p_dll_switch; is_mrs && ba == `MR1_SEL |-> dll_win_ff; endproperty
  a_dll_switch: assert property (p_dll_switch) else $error("dll bit written outside its window");
endmodule
`default_nettype wire

// ==== tb_top.sv ====
/* bench: both ends joined by the link, with a model of state, dll and read latency.
   assumes a 125 MHz mclk and the counts of cke_params.svh. */
`timescale 1ns/100ps
`default_nettype none
`include "cke_params.svh"
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin miscompares++; \
  $display("MISMATCH %s exp %0h got %0h", nm, ex, got); end end
module tb_top;
  import cke_pkg::*;
  logic mclk = 1'b0, srst = 1'b1, req_valid = 1'b0, req_pd = 1'b0, req_sr = 1'b0, req_wake = 1'b0;
  logic req_odt = 1'b0, data_busy = 1'b0;
  cmd_type req_cmd = cmd_des;
  logic [2:0] req_ba = 3'h0;
  logic [13:0] req_addr = 14'h0000;
  logic [4:0] al = 5'h00;
  logic dll_on, odt_active, illegal, refresh_busy, req_ready, dqs_seen;
  dev_state_type state;
  int miscompares = 0, n_checks = 0, n_illegal = 0, m_dll = 1, lat_q[$];
  dev_state_type m_state = st_idle;
  dram_link_if link ();
  dram_cke_device i_dram_cke_device (.mclk(mclk), .srst(srst), .link(link.device), .al(al), .dll_on(dll_on),
    .odt_active(odt_active), .illegal(illegal), .refresh_busy(refresh_busy), .state(state));
  dram_cke_ctrl i_dram_cke_ctrl (.mclk(mclk), .srst(srst), .link(link.ctrl), .req_valid(req_valid),
    .req_cmd(req_cmd), .req_ba(req_ba), .req_addr(req_addr), .req_pd(req_pd), .req_sr(req_sr),
    .req_wake(req_wake), .req_odt(req_odt), .data_busy(data_busy), .req_ready(req_ready), .dqs_seen(dqs_seen));
  dram_cke_assertions i_dram_cke_assertions (.mclk(mclk), .srst(srst), .cke(link.cke), .cs_n(link.cs_n),
    .act_n(link.act_n), .ras_n(link.ras_n), .cas_n(link.cas_n), .we_n(link.we_n), .ba(link.ba),
    .addr(link.addr), .dqs_start(link.dqs_start), .al(al));
  always #4 mclk = ~mclk;
  always @(posedge mclk) if (illegal === 1'b1) n_illegal++;

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  // one-cycle pulses with retry, since a request that lands in a delay window is dropped
  task automatic req(input cmd_type c, input logic [2:0] b, input logic [13:0] a);
    for (int i = 0; i < 800; i++) begin
      @(posedge mclk);
      req_valid <= 1'b1;
      req_cmd <= c;
      req_ba <= b;
      req_addr <= a;
      @(posedge mclk);
      req_valid <= 1'b0;
      #1;
      if (req_ready === 1'b1) return;
    end
    miscompares++;
    finish_test();
  endtask
  task automatic lvl(input int w, input dev_state_type s, input int post);
    int i;
    @(posedge mclk);
    req_pd <= (w == 0);
    req_sr <= (w == 1);
    req_wake <= (w == 2);
    for (i = 0; i < 800 && link.cke !== (w == 2); i++) @(posedge mclk);
    if (i == 800) begin
      miscompares++;
      finish_test();
    end
    req_pd <= 1'b0;
    req_sr <= 1'b0;
    req_wake <= 1'b0;
    m_state = s;
    tick(post);
    `CHK("state", m_state, state)
  endtask
  task automatic rd_check(input logic [2:0] b);
    int k;
    lat_q.push_back(int'(al) + (m_dll ? `DLLOFF_CL : `DLLOFF_CL - 1));
    req(cmd_rd, b, 14'h0000);
    for (k = 1; k < 64; k++) begin
      @(posedge mclk);
      #1;
      if (link.dqs_start === 1'b1) break;
    end
    `CHK("rd_lat", lat_q.pop_front(), k)
    tick(1);
    `CHK("dqs_seen", 1, dqs_seen)
  endtask

  initial begin
    int b;
    logic [13:0] row;
    void'($urandom(87));
    al <= 5'($urandom % 8);
    b = $urandom % 8;
    row = 14'($urandom);
    repeat (10) @(posedge mclk);
    srst <= 1'b0;
    tick(2);
    `CHK("state", st_idle, state)
    `CHK("dll_on", 1, dll_on)
    `CHK("refresh_busy", 0, refresh_busy)
    lvl(2, st_idle, 3);
    req(cmd_mrs, 3'h0, 14'h0000);
    req(cmd_mrs, `MR1_SEL, 14'h0000);
    m_dll = 0;
    tick(2);
    `CHK("dll_on", m_dll, dll_on)
    req(cmd_act, 3'(b), row);
    tick(2);
    `CHK("state", st_active, state)
    rd_check(3'(b));
    tick(8);
    lvl(0, st_pd_act, 3);
    lvl(2, st_active, 3);
    req(cmd_wr, 3'(b), 14'h0000);
    req(cmd_prea, 3'h0, 14'h0400);
    tick(8);
    `CHK("state", st_idle, state)
    req(cmd_zq, 3'h0, 14'h0000);
    req(cmd_ref, 3'h0, 14'h0000);
    lvl(0, st_pd_pre, 8);
    `CHK("refresh_busy", 0, refresh_busy)
    lvl(2, st_idle, 3);
    @(posedge mclk) req_odt <= 1'b1;
    tick(3);
    `CHK("odt_active", 1, odt_active)
    @(posedge mclk) data_busy <= 1'b1;
    req_sr <= 1'b1;
    tick(6);
    `CHK("cke", 1, link.cke)
    @(posedge mclk) data_busy <= 1'b0;
    req_sr <= 1'b0;
    lvl(1, st_self_refresh, 3);
    `CHK("odt_active", 0, odt_active)
    `CHK("refresh_busy", 1, refresh_busy)
    @(posedge mclk) req_odt <= 1'b0;
    lvl(2, st_idle, 60);
    req(cmd_act, 3'(b), row);
    rd_check(3'(b));
    req(cmd_pre, 3'(b), 14'h0000);
    lvl(0, st_pd_pre, 3);
    `CHK("illegal", 0, n_illegal)
    finish_test();
  end
endmodule
`default_nettype wire
